// ---- core/etc_timer.sv ----
// eight-bit timer/counter with two compare units, Avalon-MM register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "etc_defs.svh"

// Notes on behaviour
// - count and compare values are CPU registers
// - flag register, mask register gate each request
// - tick from clock, prescaler or external pin
// - select picks source and active edge
// - select zero stops and holds counter
// - compares watched continuously against count
// - floor signalled at count zero
// - ceiling signalled at count 255
// - limit is 255 or compare A
// - tick clears, increments or decrements counter
// - counter accessible with or without tick
// - CPU counter write beats counting
// - three-bit mode split over two controls
// - overflow flag set per waveform mode
// - overflow, match A, match B interrupt sources
// - two compare units, flag plus waveform
// - match flag on next tick, W1C
// - counter write blocks next tick's matches
module etc_timer
    import etc_pkg::*;
(
    input wire logic clock_i, // system clock
    input wire logic nrst_i, // async active-low reset
    input wire logic clk_en_i, // freezes all state but the reset synchroniser while low
    input wire logic [3:0] avs_address_i, // register index
    input wire logic avs_read_i, // read strobe
    input wire logic avs_write_i, // write strobe
    input wire logic [31:0] avs_writedata_i, // write data
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    input wire logic external_count_input_i, // external count pin
    input wire logic irq_ack_i, // interrupt serviced pulse
    input wire logic [2:0] irq_ack_sel_i, // which flag serviced
    output logic irq_o, // level interrupt
    output logic waveform_output_a_o, // compare A match pulse source
    output logic waveform_output_b_o // compare B match pulse source
);
    // ----------------------------------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_s1_q, rst_n_q;
    logic ext_s1_q, ext_s2_q, ext_prev_q;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
    logic [7:0] count_value_q, count_value_d;
    logic [7:0] compare_value_a_q, compare_value_a_d;
    logic [7:0] compare_value_b_q, compare_value_b_d;
    logic [2:0] timer_mask_register_q, timer_mask_register_d;
    logic [2:0] timer_flag_register_q, timer_flag_register_d;
    logic [`ETC_PRE_W-1:0] pre_q, pre_d;
    logic dir_down_q, dir_down_d;
    logic block_q, block_d;
    logic [1:0] match_pend_q, match_pend_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    logic irq_q, irq_d, wave_a_q, wave_a_d, wave_b_q, wave_b_d;

    etc_wmode_t wmode;
    logic [2:0] tick_source_select;
    logic timer_tick, at_floor, at_ceiling, at_limit;
    logic [7:0] limit;
    logic ext_rise, ext_fall;
    logic bus_wr, bus_rd;
    logic [7:0] wbyte;
    etc_events_t ev;

    // ----------------------------------------------------------------
    // tick selection
    // ----------------------------------------------------------------
    assign tick_source_select = ctrl_b_q[2:0];
    assign ext_rise = ext_s2_q & ~ext_prev_q;
    assign ext_fall = ~ext_s2_q & ext_prev_q;

    always_comb begin
        pre_d = pre_q + `ETC_PRE_W'(1);
        timer_tick = 1'b0;
        unique case (tick_source_select)
            `ETC_CS_NONE: timer_tick = 1'b0;
            `ETC_CS_DIRECT: timer_tick = 1'b1;
            3'h2: timer_tick = (pre_q[2:0] == 3'h7);
            3'h3: timer_tick = (pre_q[5:0] == 6'h3F);
            3'h4: timer_tick = (pre_q[7:0] == 8'hFF);
            3'h5: timer_tick = (pre_q == 10'h3FF);
            `ETC_CS_EXT_FALL: timer_tick = ext_fall;
            `ETC_CS_EXT_RISE: timer_tick = ext_rise;
        endcase
    end

    // ----------------------------------------------------------------
    // counter and compare
    // ----------------------------------------------------------------
    assign wmode = etc_wmode_t'({ctrl_b_q[`ETC_BIT_WGM2], ctrl_a_q[1:0]});
    assign limit = wmode[2] ? compare_value_a_q : `ETC_MAX_VAL;
    assign at_floor = (count_value_q == `ETC_BOTTOM_VAL);
    assign at_ceiling = (count_value_q == `ETC_MAX_VAL);
    assign at_limit = (count_value_q == limit);
    // writes land on the answer edge, the only edge at which the master counts them done
    assign bus_wr = avs_write_i & ~wait_q;
    assign bus_rd = avs_read_i & wait_q;
    assign wbyte = avs_writedata_i[7:0];

    always_comb begin
        count_value_d = count_value_q;
        dir_down_d = dir_down_q;
        ev = '0;
        // a match found now raises its flag at the next tick
        match_pend_d = match_pend_q | {count_value_q == compare_value_b_q,
                                       count_value_q == compare_value_a_q};
        block_d = block_q;
        if (timer_tick) begin
            unique case (wmode)
                ETC_WM_CTC: begin
                    count_value_d = (count_value_q == compare_value_a_q) ?
                                    `ETC_BOTTOM_VAL : count_value_q + 8'h01;
                    ev.overflow = at_ceiling;
                end
                ETC_WM_FAST_MAX, ETC_WM_FAST_CMP: begin
                    count_value_d = at_limit ? `ETC_BOTTOM_VAL : count_value_q + 8'h01;
                    ev.overflow = at_limit;
                end
                ETC_WM_PC_MAX, ETC_WM_PC_CMP: begin
                    if (dir_down_q && at_floor) begin
                        dir_down_d = 1'b0;
                        count_value_d = count_value_q + 8'h01;
                        ev.overflow = 1'b1;
                    end else if (!dir_down_q && at_limit) begin
                        dir_down_d = 1'b1;
                        count_value_d = count_value_q - 8'h01;
                    end else begin
                        count_value_d = dir_down_q ? count_value_q - 8'h01 :
                                                     count_value_q + 8'h01;
                    end
                end
                default: begin
                    count_value_d = count_value_q + 8'h01;
                    ev.overflow = at_ceiling;
                end
            endcase
            // the live compare is included so a tick every cycle still flags one tick on
            ev.match_a = (match_pend_q[0] | (count_value_q == compare_value_a_q))
                         & ~block_q;
            ev.match_b = (match_pend_q[1] | (count_value_q == compare_value_b_q))
                         & ~block_q;
            match_pend_d = {count_value_q == compare_value_b_q,
                            count_value_q == compare_value_a_q};
            block_d = 1'b0;
        end
        if (bus_wr && avs_address_i == `ETC_OFF_COUNT) begin
            count_value_d = wbyte;
            block_d = 1'b1;
            match_pend_d = 2'b00;
        end
    end

    // ----------------------------------------------------------------
    // registers, flags and bus
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] set_v, clr_v;
        set_v = {ev.match_b, ev.match_a, ev.overflow};
        clr_v = irq_ack_i ? irq_ack_sel_i : 3'b000;
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        compare_value_a_d = compare_value_a_q;
        compare_value_b_d = compare_value_b_q;
        timer_mask_register_d = timer_mask_register_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        if (bus_wr) begin
            unique case (avs_address_i)
                `ETC_OFF_CTRL_A: ctrl_a_d = {6'h00, wbyte[1:0]};
                `ETC_OFF_CTRL_B: ctrl_b_d = {4'h0, wbyte[3:0]};
                `ETC_OFF_CMP_A: compare_value_a_d = wbyte;
                `ETC_OFF_CMP_B: compare_value_b_d = wbyte;
                `ETC_OFF_MASK: timer_mask_register_d = wbyte[2:0];
                `ETC_OFF_FLAG: clr_v = clr_v | wbyte[2:0];
                default: ;
            endcase
        end
        if (bus_rd) begin
            unique case (avs_address_i)
                `ETC_OFF_CTRL_A: rdata_d = {24'h000000, ctrl_a_q};
                `ETC_OFF_CTRL_B: rdata_d = {24'h000000, ctrl_b_q};
                `ETC_OFF_COUNT: rdata_d = {24'h000000, count_value_q};
                `ETC_OFF_CMP_A: rdata_d = {24'h000000, compare_value_a_q};
                `ETC_OFF_CMP_B: rdata_d = {24'h000000, compare_value_b_q};
                `ETC_OFF_MASK: rdata_d = {29'h0, timer_mask_register_q};
                `ETC_OFF_FLAG: rdata_d = {29'h0, timer_flag_register_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
        // one wait cycle per access; the first edge of a request drops waitrequest, the answer edge raises it again
        if ((avs_read_i | avs_write_i) && wait_q) begin
            wait_d = 1'b0;
        end
        // set beats clear so an event in the clearing cycle survives
        timer_flag_register_d = (timer_flag_register_q & ~clr_v) | set_v;
        irq_d = |(timer_flag_register_d & timer_mask_register_d);
        wave_a_d = ev.match_a;
        wave_b_d = ev.match_b;
    end

    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            ctrl_a_q <= `ETC_RST_BYTE;
            ctrl_b_q <= `ETC_RST_BYTE;
            count_value_q <= `ETC_RST_BYTE;
            compare_value_a_q <= `ETC_RST_BYTE;
            compare_value_b_q <= `ETC_RST_BYTE;
            timer_mask_register_q <= 3'h0;
            timer_flag_register_q <= 3'h0;
            pre_q <= '0;
            dir_down_q <= 1'b0;
            block_q <= 1'b0;
            match_pend_q <= 2'b00;
            rdata_q <= 32'h00000000;
            wait_q <= 1'b1;
            irq_q <= 1'b0;
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else if (clk_en_i) begin
            ext_s1_q <= external_count_input_i;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            count_value_q <= count_value_d;
            compare_value_a_q <= compare_value_a_d;
            compare_value_b_q <= compare_value_b_d;
            timer_mask_register_q <= timer_mask_register_d;
            timer_flag_register_q <= timer_flag_register_d;
            pre_q <= pre_d;
            dir_down_q <= dir_down_d;
            block_q <= block_d;
            match_pend_q <= match_pend_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            irq_q <= irq_d;
            wave_a_q <= wave_a_d;
            wave_b_q <= wave_b_d;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_o = irq_q;
    assign waveform_output_a_o = wave_a_q;
    assign waveform_output_b_o = wave_b_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_stop_hold: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && tick_source_select == `ETC_CS_NONE && !bus_wr)
        |=> count_value_q == $past(count_value_q))
        else $error("counter moved with no tick source");
    chk_write_wins: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_wr && avs_address_i == `ETC_OFF_COUNT)
        |=> count_value_q == $past(wbyte))
        else $error("counter write lost");
    chk_match_block: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_wr && avs_address_i == `ETC_OFF_COUNT) |=> block_q)
        else $error("match block not armed");
    chk_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        ##1 irq_o == |(timer_flag_register_q & timer_mask_register_q))
        else $error("interrupt not gated by mask");
    chk_normal_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && wmode == ETC_WM_NORMAL && at_ceiling && !bus_wr)
        |=> timer_flag_register_q[`ETC_BIT_OVF] && count_value_q == 8'h00)
        else $error("overflow not raised at wrap");
    chk_tick_step: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && wmode == ETC_WM_NORMAL && !bus_wr)
        |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("normal mode did not increment");
    chk_ctc_clear: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && wmode == ETC_WM_CTC && !bus_wr
         && count_value_q == compare_value_a_q) |=> count_value_q == 8'h00)
        else $error("clear on compare missed");
    chk_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_flag_register_q[0] && !irq_ack_i && !bus_wr)
        |=> timer_flag_register_q[0])
        else $error("overflow flag dropped without clear");
    chk_bus_answer: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && (avs_read_i || avs_write_i) && wait_q) |=> !avs_waitrequest_o)
        else $error("bus answer late");

    // ----------------------------------------------------------------
    // checks on flags, pulses, counting modes and register access
    // ----------------------------------------------------------------
    // a flag raised in the cycle of an acknowledge must survive it
    chk_flag_seta: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && ev.match_a) |=> timer_flag_register_q[`ETC_BIT_CMPA])
        else $error("compare A flag not raised");
    chk_flag_setb: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && ev.match_b) |=> timer_flag_register_q[`ETC_BIT_CMPB])
        else $error("compare B flag not raised");
    chk_wave_a_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && ev.match_a) |=> waveform_output_a_o)
        else $error("waveform A pulse missing");
    chk_wave_b_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && ev.match_b) |=> waveform_output_b_o)
        else $error("waveform B pulse missing");
    chk_pc_top_turn: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && !bus_wr && !dir_down_q && at_limit
         && (wmode == ETC_WM_PC_MAX || wmode == ETC_WM_PC_CMP)) |=> dir_down_q)
        else $error("phase correct did not turn at top");
    chk_pc_bottom_ovf: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && !bus_wr && dir_down_q && at_floor
         && (wmode == ETC_WM_PC_MAX || wmode == ETC_WM_PC_CMP))
        |=> timer_flag_register_q[`ETC_BIT_OVF] && !dir_down_q)
        else $error("phase correct bottom turn missed");
    chk_fast_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && !bus_wr && at_limit
         && (wmode == ETC_WM_FAST_MAX || wmode == ETC_WM_FAST_CMP))
        |=> count_value_q == 8'h00 && timer_flag_register_q[`ETC_BIT_OVF])
        else $error("fast mode wrap missed");
    // no match flag may rise from the tick right after a counter write
    chk_blocked_tick: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && timer_tick && block_q)
        |=> (timer_flag_register_q[2:1] & ~$past(timer_flag_register_q[2:1])) == 2'b00)
        else $error("match not blocked after counter write");
    chk_ack_clear: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && irq_ack_i && irq_ack_sel_i[`ETC_BIT_OVF] && !ev.overflow)
        |=> !timer_flag_register_q[`ETC_BIT_OVF])
        else $error("overflow flag not cleared by service");
    chk_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_rd && avs_address_i > `ETC_OFF_FLAG) |=> avs_readdata_o == 32'h00000000)
        else $error("unmapped index read not zero");
    chk_read_count: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_rd && avs_address_i == `ETC_OFF_COUNT)
        |=> avs_readdata_o == {24'h000000, $past(count_value_q)})
        else $error("counter read wrong");
    chk_cmp_write: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_wr && avs_address_i == `ETC_OFF_CMP_A)
        |=> compare_value_a_q == $past(wbyte))
        else $error("compare A write lost");
    chk_mode_write: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_wr && avs_address_i == `ETC_OFF_CTRL_B)
        |=> ctrl_b_q == {4'h0, $past(wbyte[3:0])})
        else $error("control B write lost");
    chk_mask_write: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && bus_wr && avs_address_i == `ETC_OFF_MASK)
        |=> timer_mask_register_q == $past(wbyte[2:0]))
        else $error("mask write lost");
    // waitrequest rests high so a new request is never answered before it is taken
    chk_wait_rest: assert property (@(posedge clock_i) disable iff (!rst_n_q)
        (clk_en_i && !avs_read_i && !avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low without request");
endmodule : etc_timer

// ---- core/etc_defs.svh ----
// register offsets, field positions, reset values and tick-source codes
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

`define ETC_OFF_CTRL_A 4'h0
`define ETC_OFF_CTRL_B 4'h1
`define ETC_OFF_COUNT 4'h2
`define ETC_OFF_CMP_A 4'h3
`define ETC_OFF_CMP_B 4'h4
`define ETC_OFF_MASK 4'h5
`define ETC_OFF_FLAG 4'h6
`define ETC_BIT_OVF 0
`define ETC_BIT_CMPA 1
`define ETC_BIT_CMPB 2
`define ETC_BIT_WGM2 3
`define ETC_RST_BYTE 8'h00
`define ETC_MAX_VAL 8'hFF
`define ETC_BOTTOM_VAL 8'h00
`define ETC_CS_NONE 3'h0
`define ETC_CS_DIRECT 3'h1
`define ETC_CS_EXT_FALL 3'h6
`define ETC_CS_EXT_RISE 3'h7
`define ETC_PRE_W 10

`endif

// ---- core/etc_pkg.sv ----
// types shared by the eight-bit timer/counter
package etc_pkg;
    typedef enum logic [2:0] {
        ETC_WM_NORMAL = 3'h0,
        ETC_WM_PC_MAX = 3'h1,
        ETC_WM_CTC = 3'h2,
        ETC_WM_FAST_MAX = 3'h3,
        ETC_WM_RSV4 = 3'h4,
        ETC_WM_PC_CMP = 3'h5,
        ETC_WM_RSV6 = 3'h6,
        ETC_WM_FAST_CMP = 3'h7
    } etc_wmode_t;

    typedef struct packed {
        logic overflow;
        logic match_b;
        logic match_a;
    } etc_events_t;
endpackage : etc_pkg

// ---- tb/tb_etc_timer.sv ----
// self-checking bench for the eight-bit timer/counter, with a behavioural count model
`timescale 1ns/1ps
module tb_etc_timer import etc_pkg::*; ;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic ext = 1'b0;
    logic ack = 1'b0;
    logic en = 1'b1;
    logic [2:0] ack_sel = 3'h0;
    logic irq;
    logic wa;
    logic wb;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_wa = 0;
    int m_cnt, m_ca, m_cb, m_flg, m_mode, m_blk, m_up;
    logic [31:0] lfsr = 32'h496cf198;
    logic [31:0] q;
    logic [31:0] v;

    etc_timer uut (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(en), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .external_count_input_i(ext), .irq_ack_i(ack),
        .irq_ack_sel_i(ack_sel), .irq_o(irq), .waveform_output_a_o(wa),
        .waveform_output_b_o(wb));

    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (wa === 1'b1) n_wa++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // ----------------------------------------
    // bus cycles, comparisons and the model
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    // the request stays up until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        adr <= a;
        wd <= d;
        wr_s <= w;
        rd <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        q = rdat;
        rd <= 1'b0;
        wr_s <= 1'b0;
        if (n >= 40) err_total++;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input int e);
        bus(1'b0, a, 32'h0);
        chk(q, e[31:0]);
    endtask : rdc
    task automatic wcnt(input int c);
        wr(4'h2, c[31:0]);
        m_cnt = c;
        m_blk = 1;
    endtask : wcnt
    task automatic setmode(input int m, input int sel);
        wr(4'h0, m & 3);
        wr(4'h1, ((m >> 2) << 3) | sel);
        m_mode = m;
    endtask : setmode
    task automatic pin(input logic l);
        @(posedge clock_i);
        ext <= l;
        repeat (6) @(posedge clock_i);
    endtask : pin
    // one tick of the counter as the waveform mode defines it
    function automatic void mstep();
        int top;
        top = (m_mode == 2 || m_mode == 5 || m_mode == 7) ? m_ca : 255;
        if (!m_blk && m_cnt == m_ca) m_flg |= 2;
        if (!m_blk && m_cnt == m_cb) m_flg |= 4;
        m_blk = 0;
        if (m_mode == 1 || m_mode == 5) begin
            if (m_up && m_cnt == top) m_up = 0;
            else if (!m_up && m_cnt == 0) begin
                m_up = 1;
                m_flg |= 1;
            end
            m_cnt = m_up ? m_cnt + 1 : m_cnt - 1;
        end else begin
            if (m_cnt == ((m_mode == 2) ? 255 : top)) m_flg |= 1;
            m_cnt = (m_cnt == top) ? 0 : (m_cnt + 1) & 255;
        end
    endfunction : mstep
    task automatic tick(input int n);
        repeat (n) begin
            pin(1'b1);
            pin(1'b0);
            mstep();
        end
    endtask : tick
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        m_cnt = 0;
        m_ca = 0;
        m_cb = 0;
        m_flg = 0;
        m_mode = 0;
        m_blk = 0;
        m_up = 1;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        for (int a = 0; a < 8; a++) rdc(a[3:0], 0);
        wr(4'h7, 32'hFF);
        rdc(4'h7, 0);
        for (int a = 2; a < 5; a++) begin
            v = rnd();
            wr(a[3:0], v);
            if (a == 2) m_cnt = v & 32'hFF;
            rdc(a[3:0], v & 32'hFF);
        end
        repeat (40) @(posedge clock_i);
        rdc(4'h2, m_cnt);
        wcnt(8'h40);
        rdc(4'h2, 8'h40);
        // source select codes 1..5 must all move the counter, 0 must freeze it
        for (int s = 1; s < 6; s++) begin
            setmode(0, s);
            repeat (1100) @(posedge clock_i);
            setmode(0, 0);
            bus(1'b0, 4'h2, 32'h0);
            chk(q !== m_cnt[31:0], 1'b1);
            m_cnt = q;
        end
        rdc(4'h2, m_cnt);
        setmode(0, 1);
        wr(4'h2, 32'h80);
        bus(1'b0, 4'h2, 32'h0);
        chk(q - 32'h80 < 32'h10, 1'b1);
        setmode(0, 7);
        m_ca = 8'h10;
        m_cb = 8'h20;
        wr(4'h3, m_ca);
        wr(4'h4, m_cb);
        wcnt(8'hC0);
        wr(4'h6, 32'h7);
        m_flg = 0;
        pin(1'b1);
        mstep();
        rdc(4'h2, m_cnt);
        pin(1'b0);
        rdc(4'h2, m_cnt);
        setmode(0, 6);
        pin(1'b1);
        rdc(4'h2, m_cnt);
        pin(1'b0);
        mstep();
        rdc(4'h2, m_cnt);
        setmode(0, 7);
        wcnt(8'hFE);
        tick(3);
        rdc(4'h2, m_cnt);
        rdc(4'h6, m_flg);
        wr(4'h5, 32'h1);
        repeat (2) @(posedge clock_i);
        chk(irq, 1'b1);
        wr(4'h5, 32'h6);
        repeat (2) @(posedge clock_i);
        chk(irq, 1'b0);
        wr(4'h6, 32'h0);
        rdc(4'h6, m_flg);
        wr(4'h6, 32'h1);
        m_flg = 0;
        rdc(4'h6, 0);
        wcnt(8'h0E);
        n_wa = 0;
        tick(2);
        rdc(4'h6, m_flg);
        tick(1);
        rdc(4'h6, 2);
        chk(n_wa, 1);
        repeat (2) @(posedge clock_i);
        chk(irq, 1'b1);
        @(posedge clock_i);
        ack <= 1'b1;
        ack_sel <= 3'h2;
        @(posedge clock_i);
        ack <= 1'b0;
        m_flg = 0;
        rdc(4'h6, m_flg);
        wcnt(m_cb);
        tick(1);
        rdc(4'h6, m_flg);
        m_ca = 8'hFE;
        m_cb = 8'h40;
        wr(4'h3, m_ca);
        wr(4'h4, m_cb);
        // every waveform mode is run four ticks from the same start; end count and flags are checked against the model
        for (int m = 0; m < 8; m++) begin
            setmode(m, 7);
            wcnt(8'hFC);
            wr(4'h6, 32'h7);
            m_flg = 0;
            tick(4);
            rdc(4'h2, m_cnt);
            rdc(4'h6, m_flg);
        end
        // an external edge while the enable is low must leave no trace
        @(posedge clock_i);
        en <= 1'b0;
        pin(1'b1);
        pin(1'b0);
        @(posedge clock_i);
        en <= 1'b1;
        rdc(4'h2, m_cnt);
        end_sim();
    end
endmodule : tb_etc_timer
